// File: hmbh_map.vh
`ifndef HMBH_MAP_VH
`define HMBH_MAP_VH

// ------------------------------------------------------------------
// Register word indices (byte address is four times the index).
// ------------------------------------------------------------------
`define HMBH_IDX_CTRL 3'h0
`define HMBH_IDX_ADDR 3'h1
`define HMBH_IDX_WDATA 3'h2
`define HMBH_IDX_RDATA 3'h3
`define HMBH_IDX_STATUS 3'h4
`define HMBH_IDX_IRQ_STAT 3'h5
`define HMBH_IDX_IRQ_MASK 3'h6

// ------------------------------------------------------------------
// Control register fields.
// ------------------------------------------------------------------
`define HMBH_CTRL_SYNC 0
`define HMBH_CTRL_LATCH 1
`define HMBH_CTRL_GO 2
`define HMBH_CTRL_WR 3
`define HMBH_CTRL_CNT_LO 8
`define HMBH_CTRL_CNT_HI 15

// ------------------------------------------------------------------
// Status register fields.
// ------------------------------------------------------------------
`define HMBH_STAT_BUSY 0
`define HMBH_STAT_HOLD 1
`define HMBH_STAT_ACK 2
`define HMBH_STAT_REM_LO 8
`define HMBH_STAT_REM_HI 15

// ------------------------------------------------------------------
// Interrupt status and mask bits.
// ------------------------------------------------------------------
`define HMBH_IRQ_W 3
`define HMBH_IRQ_DONE 0
`define HMBH_IRQ_RETRY 1
`define HMBH_IRQ_SLAVE 2

// ------------------------------------------------------------------
// Reset values.
// ------------------------------------------------------------------
`define HMBH_RST_CTRL 32'h0000_0000
`define HMBH_RST_WORD 32'h0000_0000
`define HMBH_RST_IRQ 3'h0

// ------------------------------------------------------------------
// Address step between words of a burst.
// ------------------------------------------------------------------
`define HMBH_ADDR_STEP 32'h0000_0004

`endif

// File: hmbh_sync.v
`default_nettype none

// ------------------------------------------------------------------
// Two flip-flop synchroniser for a vector of unrelated levels.
// ------------------------------------------------------------------
module hmbh_sync #(
    parameter W = 8
) (
    input wire hclk,
    input wire hresetn,
    input wire [W-1:0] d,
    output reg [W-1:0] q
);

    reg [W-1:0] meta_reg;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            meta_reg <= {W{1'b0}};
            q <= {W{1'b0}};
        end else begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end

endmodule

`default_nettype wire

// File: hmbh_top.v
// Notes on behaviour
// [R1] Direction strobe low reads, high writes.
// [R2] Interrupt output follows only unmasked pending events.
// [R3] Hold request high only while bus wanted.
// [R4] Master cycles start only after hold acknowledge.
// [R5] Grant acknowledge pin unused in this mode.
// [R6] Host drives slave strobe low read, high write.
// [R7] Ready input high stretches, low ends cycle.
// [R8] Ready sampling style chosen by sync select bit.
// [R9] Ready output signals each host register access.
// [R10] Address strobe rising edge marks valid address.
// [R11] Retry ends cycle, repeats it after release.
// [R12] Host never overlaps chip select and memory request.
// [R13] Hold request kept until all pending words finish.
//
// Chosen here: the AHB-Lite register port and the placing of the registers.
`include "hmbh_map.vh"
`default_nettype none

module hmbh_top (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output wire hreadyout,
    output wire hresp,
    output reg [31:0] hrdata,
    output wire hold_req,
    input wire bus_hold_ack,
    output reg [31:0] mem_addr,
    output wire mem_addr_oe,
    input wire [31:0] mem_data_in,
    output wire [31:0] mem_data_out,
    output wire mem_data_oe,
    output wire mem_dir_strobe,
    output wire mem_dir_strobe_oe,
    output wire addr_valid_strobe,
    output wire addr_valid_strobe_oe,
    input wire master_ready_in,
    input wire bus_retry_in,
    output wire grant_confirm,
    output wire grant_confirm_oe,
    input wire slave_cs_n,
    input wire [2:0] slave_addr,
    input wire slave_dir_strobe,
    input wire [31:0] slave_data_in,
    output reg [31:0] slave_data_out,
    output reg slave_data_oe,
    output reg slave_ready_out,
    output wire irq
);

    // --------------------------------------------------------------
    // Master state codes.
    // --------------------------------------------------------------
    localparam [2:0] S_IDLE = 3'h0;
    localparam [2:0] S_HOLD = 3'h1;
    localparam [2:0] S_ADDR = 3'h2;
    localparam [2:0] S_DATA = 3'h3;
    localparam [2:0] S_RETRY = 3'h4;

    // --------------------------------------------------------------
    // Pin synchronisation.
    // --------------------------------------------------------------
    wire [71:0] pin_raw;
    wire [71:0] pin_s;
    wire ack_s;
    wire rdy_s;
    wire retry_s;
    wire cs_n_s;
    wire sdir_s;
    wire [2:0] saddr_s;
    wire [31:0] mdata_s;
    wire [31:0] sdata_s;

    assign pin_raw = {bus_hold_ack, master_ready_in, bus_retry_in,
                      slave_cs_n, slave_dir_strobe, slave_addr,
                      mem_data_in, slave_data_in};

    hmbh_sync #(
        .W(72)
    ) u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .d(pin_raw),
        .q(pin_s)
    );

    assign ack_s = pin_s[71];
    assign rdy_s = pin_s[70];
    assign retry_s = pin_s[69];
    assign cs_n_s = pin_s[68];
    assign sdir_s = pin_s[67];
    assign saddr_s = pin_s[66:64];
    assign mdata_s = pin_s[63:32];
    assign sdata_s = pin_s[31:0];

    // --------------------------------------------------------------
    // State.
    // --------------------------------------------------------------
    reg [31:0] ctrl_reg;
    reg [31:0] addr_reg;
    reg [31:0] wdata_reg;
    reg [31:0] rdata_reg;
    reg [`HMBH_IRQ_W-1:0] irq_stat_reg;
    reg [`HMBH_IRQ_W-1:0] irq_mask_reg;
    reg [2:0] state_reg;
    reg [7:0] remain_reg;
    reg dir_wr_reg;
    reg rdy_prev_reg;
    reg ahb_wr_reg;
    reg [2:0] ahb_idx_reg;
    reg cs_prev_reg;
    reg pin_pend_reg;
    reg pin_wr_reg;
    reg [2:0] pin_idx_reg;

    // --------------------------------------------------------------
    // Register read multiplexer.
    // --------------------------------------------------------------
    function [31:0] rd_mux;
        input [2:0] idx;
        begin
            rd_mux = 32'h0000_0000;
            case (idx)
                `HMBH_IDX_CTRL: rd_mux = ctrl_reg;
                `HMBH_IDX_ADDR: rd_mux = addr_reg;
                `HMBH_IDX_WDATA: rd_mux = wdata_reg;
                `HMBH_IDX_RDATA: rd_mux = rdata_reg;
                `HMBH_IDX_STATUS: begin
                    rd_mux[`HMBH_STAT_BUSY] = (state_reg != S_IDLE);
                    rd_mux[`HMBH_STAT_HOLD] = hold_req;
                    rd_mux[`HMBH_STAT_ACK] = ack_s;
                    rd_mux[`HMBH_STAT_REM_HI:`HMBH_STAT_REM_LO] =
                        remain_reg;
                end
                `HMBH_IDX_IRQ_STAT:
                    rd_mux[`HMBH_IRQ_W-1:0] = irq_stat_reg;
                `HMBH_IDX_IRQ_MASK:
                    rd_mux[`HMBH_IRQ_W-1:0] = irq_mask_reg;
                default: rd_mux = 32'h0000_0000;
            endcase
        end
    endfunction

    // --------------------------------------------------------------
    // AHB-Lite slave: zero wait states, always OKAY.
    // --------------------------------------------------------------
    wire ahb_take;
    wire ahb_mapped;

    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign ahb_take = hsel & htrans[1] & hready;
    assign ahb_mapped = (haddr[31:5] == 27'h0000000);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ahb_wr_reg <= 1'b0;
            ahb_idx_reg <= 3'h0;
            hrdata <= `HMBH_RST_WORD;
        end else begin
            ahb_wr_reg <= ahb_take & hwrite & ahb_mapped &
                          (hsize == 3'b010);
            if (ahb_take) begin
                ahb_idx_reg <= haddr[4:2];
            end
            if (ahb_take & !hwrite) begin
                hrdata <= ahb_mapped ? rd_mux(haddr[4:2]) :
                          32'h0000_0000;
            end
        end
    end

    // --------------------------------------------------------------
    // Host pin register port.
    // --------------------------------------------------------------
    wire pin_go;
    wire wr_en;
    wire [2:0] wr_idx;
    wire [31:0] wr_data;

    // An AHB write owns the register write port; a pin write waits.
    assign pin_go = pin_pend_reg & (!pin_wr_reg | !ahb_wr_reg);
    assign wr_en = ahb_wr_reg | (pin_go & pin_wr_reg);
    assign wr_idx = ahb_wr_reg ? ahb_idx_reg : pin_idx_reg;
    assign wr_data = ahb_wr_reg ? hwdata : sdata_s;

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cs_prev_reg <= 1'b0; // Matches the synchronised select at reset.
            pin_pend_reg <= 1'b0;
            pin_wr_reg <= 1'b0;
            pin_idx_reg <= 3'h0;
            slave_data_out <= `HMBH_RST_WORD;
            slave_data_oe <= 1'b0;
            slave_ready_out <= 1'b0;
        end else begin
            cs_prev_reg <= cs_n_s;
            if (cs_prev_reg & !cs_n_s) begin
                pin_pend_reg <= 1'b1;
                pin_wr_reg <= sdir_s; // [R6]
                pin_idx_reg <= saddr_s;
            end else if (pin_go) begin
                pin_pend_reg <= 1'b0;
            end
            if (pin_go) begin
                slave_ready_out <= 1'b1; // [R9]
                slave_data_oe <= !pin_wr_reg;
                if (!pin_wr_reg) begin
                    slave_data_out <= rd_mux(pin_idx_reg);
                end
            end else if (cs_n_s) begin
                slave_ready_out <= 1'b0;
                slave_data_oe <= 1'b0;
            end
        end
    end

    // --------------------------------------------------------------
    // Ready qualification.
    // --------------------------------------------------------------
    wire sync_mode;
    wire latch_mode;
    wire rdy_end;

    assign sync_mode = ctrl_reg[`HMBH_CTRL_SYNC];
    assign latch_mode = ctrl_reg[`HMBH_CTRL_LATCH];
    // Asynchronous style needs two agreeing samples before ending.
    assign rdy_end = sync_mode ? !rdy_s : (!rdy_s & !rdy_prev_reg); // [R8]

    // --------------------------------------------------------------
    // Master sequencer.
    // --------------------------------------------------------------
    wire go_pulse;
    wire [7:0] go_cnt;
    wire ev_done;
    wire ev_retry;
    wire retry_clear;

    assign go_pulse = wr_en & (wr_idx == `HMBH_IDX_CTRL) &
                      wr_data[`HMBH_CTRL_GO];
    assign go_cnt = wr_data[`HMBH_CTRL_CNT_HI:`HMBH_CTRL_CNT_LO];
    assign ev_done = (state_reg == S_DATA) & !retry_s & rdy_end &
                     (remain_reg == 8'h01);
    assign ev_retry = (state_reg == S_DATA) & retry_s;
    assign retry_clear = !retry_s &
                         (!latch_mode | !irq_stat_reg[`HMBH_IRQ_RETRY]);

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= S_IDLE;
            remain_reg <= 8'h00;
            dir_wr_reg <= 1'b0;
            mem_addr <= `HMBH_RST_WORD;
            rdata_reg <= `HMBH_RST_WORD;
            rdy_prev_reg <= 1'b1;
        end else begin
            rdy_prev_reg <= rdy_s;
            case (state_reg)
                S_IDLE: begin
                    if (go_pulse & (go_cnt != 8'h00)) begin
                        state_reg <= S_HOLD; // [R3]
                        remain_reg <= go_cnt;
                        dir_wr_reg <= wr_data[`HMBH_CTRL_WR];
                        mem_addr <= addr_reg;
                    end
                end
                S_HOLD: begin
                    if (ack_s) begin
                        state_reg <= S_ADDR; // [R4]
                    end
                end
                S_ADDR: begin
                    if (!ack_s) begin
                        state_reg <= S_HOLD; // [R4]
                    end else begin
                        state_reg <= S_DATA; // [R10]
                    end
                end
                S_DATA: begin
                    if (retry_s) begin
                        state_reg <= S_RETRY; // [R11]
                    end else if (rdy_end) begin // [R7]
                        if (!dir_wr_reg) begin
                            rdata_reg <= mdata_s;
                        end
                        mem_addr <= mem_addr + `HMBH_ADDR_STEP;
                        remain_reg <= remain_reg - 8'h01;
                        if (remain_reg == 8'h01) begin
                            state_reg <= S_IDLE; // [R13]
                        end else if (ack_s) begin
                            state_reg <= S_ADDR; // [R13]
                        end else begin
                            state_reg <= S_HOLD;
                        end
                    end
                end
                S_RETRY: begin
                    if (retry_clear) begin
                        state_reg <= ack_s ? S_ADDR : S_HOLD; // [R11]
                    end
                end
                default: state_reg <= S_IDLE;
            endcase
        end
    end

    // --------------------------------------------------------------
    // Bus pins while master.
    // --------------------------------------------------------------
    wire owning;

    assign owning = (state_reg == S_ADDR) | (state_reg == S_DATA);
    assign hold_req = (state_reg != S_IDLE); // [R3]
    assign mem_addr_oe = owning;
    assign mem_dir_strobe = dir_wr_reg; // [R1]
    assign mem_dir_strobe_oe = owning; // [R1]
    assign addr_valid_strobe = (state_reg != S_ADDR); // [R10]
    assign addr_valid_strobe_oe = owning;
    assign mem_data_out = wdata_reg;
    assign mem_data_oe = owning & dir_wr_reg;
    assign grant_confirm = 1'b1; // [R5]
    assign grant_confirm_oe = 1'b0; // [R5]

    // --------------------------------------------------------------
    // Software registers and interrupt.
    // --------------------------------------------------------------
    wire [`HMBH_IRQ_W-1:0] irq_set;
    wire [`HMBH_IRQ_W-1:0] irq_clr;

    assign irq_set = {pin_go, ev_retry, ev_done};
    assign irq_clr = (wr_en & (wr_idx == `HMBH_IDX_IRQ_STAT)) ?
                     wr_data[`HMBH_IRQ_W-1:0] : {`HMBH_IRQ_W{1'b0}};
    assign irq = |(irq_stat_reg & irq_mask_reg); // [R2]

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= `HMBH_RST_CTRL;
            addr_reg <= `HMBH_RST_WORD;
            wdata_reg <= `HMBH_RST_WORD;
            irq_stat_reg <= `HMBH_RST_IRQ;
            irq_mask_reg <= `HMBH_RST_IRQ;
        end else begin
            // A new event wins over a clear in the same cycle.
            irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set; // [R2]
            if (wr_en) begin
                case (wr_idx)
                    `HMBH_IDX_CTRL: begin
                        ctrl_reg <= wr_data & 32'h0000_ff0b;
                    end
                    `HMBH_IDX_ADDR: addr_reg <= wr_data;
                    `HMBH_IDX_WDATA: wdata_reg <= wr_data;
                    `HMBH_IDX_IRQ_MASK:
                        irq_mask_reg <= wr_data[`HMBH_IRQ_W-1:0];
                    default: ctrl_reg <= ctrl_reg;
                endcase
            end
        end
    end

endmodule

`default_nettype wire

// File: hmbh_properties.sv
`default_nettype none

module hmbh_props (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hold_req,
    input wire logic bus_hold_ack,
    input wire logic mem_addr_oe,
    input wire logic mem_data_oe,
    input wire logic mem_dir_strobe,
    input wire logic mem_dir_strobe_oe,
    input wire logic addr_valid_strobe,
    input wire logic addr_valid_strobe_oe,
    input wire logic master_ready_in,
    input wire logic bus_retry_in,
    input wire logic grant_confirm,
    input wire logic grant_confirm_oe,
    input wire logic slave_cs_n,
    input wire logic slave_ready_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge hclk);
    endclocking
    default disable iff (!hresetn);

    a_grant_unused: assert property (!grant_confirm_oe && grant_confirm)
        else $error("grant pin is driven");
    a_strobe_one_cycle: assert property ($fell(addr_valid_strobe)
        |=> addr_valid_strobe && addr_valid_strobe_oe)
        else $error("address strobe low for more than one cycle");
    a_cycle_needs_ack: assert property (!addr_valid_strobe
        |-> hold_req && $past(bus_hold_ack, 2))
        else $error("master cycle started without acknowledge");
    a_write_data_oe: assert property (mem_data_oe ==
        (mem_dir_strobe_oe && mem_dir_strobe))
        else $error("data drive does not match direction");
    a_drive_with_hold: assert property (mem_addr_oe |-> hold_req
        && mem_dir_strobe_oe && addr_valid_strobe_oe)
        else $error("bus driven without hold request");
    a_ready_stretch: assert property (addr_valid_strobe_oe
        && addr_valid_strobe && bus_hold_ack && master_ready_in
        && $past(master_ready_in) && $past(master_ready_in, 2)
        && $past(master_ready_in, 3) && !bus_retry_in
        && !$past(bus_retry_in) && !$past(bus_retry_in, 2)
        |=> addr_valid_strobe_oe)
        else $error("cycle ended while ready input high");
    a_hold_drop: assert property ($fell(hold_req) |-> !mem_addr_oe
        && (!$past(master_ready_in, 3) || !$past(master_ready_in, 4)
        || !$past(master_ready_in, 5)))
        else $error("hold request dropped before cycle end");
    a_ready_answer: assert property ($fell(slave_cs_n)
        |-> ##[3:8] slave_ready_out)
        else $error("no ready output for host access");
    a_ready_needs_cs: assert property ($rose(slave_ready_out)
        |-> !$past(slave_cs_n, 2))
        else $error("ready output without chip select");
endmodule

bind hmbh_top hmbh_props u_props (.hclk(hclk), .hresetn(hresetn),
    .hold_req(hold_req), .bus_hold_ack(bus_hold_ack),
    .mem_addr_oe(mem_addr_oe), .mem_data_oe(mem_data_oe),
    .mem_dir_strobe(mem_dir_strobe), .mem_dir_strobe_oe(mem_dir_strobe_oe),
    .addr_valid_strobe(addr_valid_strobe),
    .addr_valid_strobe_oe(addr_valid_strobe_oe),
    .master_ready_in(master_ready_in), .bus_retry_in(bus_retry_in),
    .grant_confirm(grant_confirm), .grant_confirm_oe(grant_confirm_oe),
    .slave_cs_n(slave_cs_n), .slave_ready_out(slave_ready_out));

`default_nettype wire

// File: hmbh_partner.sv
`default_nettype none

module hmbh_partner (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hold_req,
    input wire logic mem_data_oe,
    input wire logic mem_dir_strobe,
    input wire logic mem_dir_strobe_oe,
    input wire logic addr_valid_strobe,
    input wire logic addr_valid_strobe_oe,
    input wire logic [31:0] mem_addr,
    input wire logic [31:0] mem_data_out,
    input wire logic [3:0] waits,
    output logic bus_hold_ack,
    output logic master_ready_in,
    output logic [31:0] mem_data_in
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [31:0] mem [0:15];
    logic [4:0] cnt;
    logic tog;

    // Released data lines toggle so a stale word is never read.
    assign mem_data_in = (mem_dir_strobe_oe && !mem_dir_strobe) ?
        mem[mem_addr[5:2]] : {32{tog}};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_hold_ack <= 1'b0;
            master_ready_in <= 1'b1;
            cnt <= 5'h0;
            tog <= 1'b0;
            for (int i = 0; i < 16; i++) begin
                mem[i] <= 32'(i);
            end
        end else begin
            tog <= !tog;
            bus_hold_ack <= hold_req;
            if (!addr_valid_strobe_oe || !addr_valid_strobe) begin
                cnt <= 5'h0;
                master_ready_in <= 1'b1;
            end else begin
                if (cnt != 5'h1f) begin
                    cnt <= cnt + 5'h1;
                end
                // Ready goes low for two cycles only, then high again.
                master_ready_in <= !(cnt >= {1'b0, waits} &&
                    cnt <= {1'b0, waits} + 5'h1);
                if (cnt == {1'b0, waits} && mem_data_oe) begin
                    mem[mem_addr[5:2]] <= mem_data_out;
                end
            end
        end
    end
endmodule

`default_nettype wire

// File: hmbh_top_tb.sv
`include "hmbh_map.vh"
`default_nettype none
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin mismatches++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (g), (e)); end end

module hmbh_top_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, slave_cs_n = 1;
    logic slave_dir_strobe = 0, bus_retry_in = 0;
    logic [1:0] htrans = 0;
    logic [2:0] hsize = 3'h2, slave_addr = 0;
    logic [3:0] waits = 0;
    logic [31:0] haddr = 0, hwdata = 0, slave_data_in = 0, seed = 89, rd;
    logic [31:0] sh [0:15];
    wire hready, hreadyout, hresp, hold_req, bus_hold_ack, irq;
    wire mem_addr_oe, mem_data_oe, mem_dir_strobe, mem_dir_strobe_oe;
    wire addr_valid_strobe, addr_valid_strobe_oe, master_ready_in;
    wire grant_confirm, grant_confirm_oe, slave_data_oe, slave_ready_out;
    wire [31:0] hrdata, mem_addr, mem_data_in, mem_data_out, slave_data_out;
    int mismatches = 0, tests_run = 0, cyc = 0;

    assign hready = hreadyout;
    always #2.5 hclk = ~hclk;
    hmbh_top uut (.*);
    hmbh_partner partner (.*);

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [31:0] ra(input logic [2:0] i);
        return {27'h0, i, 2'h0};
    endfunction
    function automatic logic [31:0] ctl(input logic [7:0] n,
        input logic wr, lt, sy);
        return {16'h0, n, 4'h0, wr, 1'b1, lt, sy};
    endfunction

    task automatic ahb(input logic w, input logic [31:0] a, d);
        if (!hclk) @(posedge hclk);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= w;
        htrans <= 2'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
    endtask
    task automatic rchk(input logic [2:0] i, input logic [31:0] e);
        ahb(1'b0, ra(i), 32'h0);
        `CHK({hresp, rd}, {1'b0, e})
    endtask
    task automatic dma(input logic wr, sy, input logic [7:0] n);
        ahb(1'b1, ra(`HMBH_IDX_CTRL), ctl(n, wr, 1'b0, sy));
        repeat (2) @(posedge hclk);
        while (hold_req !== 1'b0) @(posedge hclk);
    endtask
    task automatic pin(input logic w, input logic [2:0] i,
        input logic [31:0] d);
        slave_dir_strobe <= w;
        slave_addr <= i;
        slave_data_in <= d;
        @(posedge hclk);
        slave_cs_n <= 1'b0;
        do @(posedge hclk); while (slave_ready_out !== 1'b1);
        rd = slave_data_out;
        `CHK(slave_data_oe, !w)
        slave_cs_n <= 1'b1;
        repeat (6) @(posedge hclk);
    endtask
    task automatic report_and_stop;
        if (mismatches == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    always @(posedge hclk) begin
        cyc++;
        if (cyc == 20000) begin
            mismatches++;
            report_and_stop;
        end
    end

    initial begin
        logic [31:0] r, d;
        logic [7:0] n;
        logic [2:0] b;
        for (int i = 0; i < 16; i++) sh[i] = 32'(i);
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        @(negedge hclk);
        `CHK({hold_req, irq, addr_valid_strobe, grant_confirm_oe}, 4'h2)
        rchk(`HMBH_IDX_CTRL, `HMBH_RST_CTRL);
        rchk(`HMBH_IDX_STATUS, `HMBH_RST_WORD);
        rchk(3'h7, 32'h0);
        ahb(1'b0, 32'h40, 32'h0);
        `CHK(rd, 32'h0)
        ahb(1'b1, ra(`HMBH_IDX_IRQ_MASK), 32'h1);
        for (int t = 0; t < 6; t++) begin
            r = xs();
            d = xs();
            n = 8'h1 + r[1:0];
            b = r[4:2];
            waits <= {1'b0, r[7:5]};
            ahb(1'b1, ra(`HMBH_IDX_ADDR), {27'h0, b, 2'h0});
            ahb(1'b1, ra(`HMBH_IDX_WDATA), d);
            dma(1'b1, r[8], n);
            for (int k = 0; k < n; k++) sh[b + k] = d;
            for (int k = 0; k < 16; k++) `CHK(partner.mem[k], sh[k])
            dma(1'b0, !r[8], n);
            rchk(`HMBH_IDX_RDATA, d);
            @(negedge hclk);
            `CHK(irq, 1'b1)
            ahb(1'b1, ra(`HMBH_IDX_IRQ_MASK), 32'h0);
            @(negedge hclk);
            `CHK(irq, 1'b0)
            ahb(1'b1, ra(`HMBH_IDX_IRQ_STAT), 32'h7);
            rchk(`HMBH_IDX_IRQ_STAT, 32'h0);
            ahb(1'b1, ra(`HMBH_IDX_IRQ_MASK), 32'h1);
        end
        for (int lt = 0; lt < 2; lt++) begin
            d = xs();
            waits <= 4'h6;
            ahb(1'b1, ra(`HMBH_IDX_WDATA), d);
            ahb(1'b1, ra(`HMBH_IDX_ADDR), 32'h0);
            ahb(1'b1, ra(`HMBH_IDX_CTRL), ctl(8'h1, 1'b1, lt[0], 1'b1));
            do @(posedge hclk); while (addr_valid_strobe_oe !== 1'b1);
            bus_retry_in <= 1'b1;
            repeat (4) @(posedge hclk);
            bus_retry_in <= 1'b0;
            if (lt == 1) begin
                repeat (20) @(posedge hclk);
                @(negedge hclk);
                `CHK({hold_req, addr_valid_strobe_oe, irq}, 3'h4)
                rchk(`HMBH_IDX_IRQ_STAT, 32'h2);
                rchk(`HMBH_IDX_STATUS, 32'h0000_0107);
                ahb(1'b1, ra(`HMBH_IDX_IRQ_STAT), 32'h2);
            end
            while (hold_req !== 1'b0) @(posedge hclk);
            `CHK(partner.mem[0], d)
            rchk(`HMBH_IDX_IRQ_STAT, (lt == 1) ? 32'h1 : 32'h3);
            ahb(1'b1, ra(`HMBH_IDX_IRQ_STAT), 32'h7);
        end
        pin(1'b1, `HMBH_IDX_IRQ_MASK, 32'h5);
        rchk(`HMBH_IDX_IRQ_MASK, 32'h5);
        pin(1'b0, `HMBH_IDX_IRQ_STAT, 32'h0);
        `CHK(rd, 32'h4)
        @(negedge hclk);
        `CHK(irq, 1'b1)
        ahb(1'b1, ra(`HMBH_IDX_IRQ_MASK), 32'h1);
        @(negedge hclk);
        `CHK(irq, 1'b0)
        report_and_stop;
    end
endmodule

`default_nettype wire
